// file: hw/cpa_map.svh
// Offsets, field positions, reset values and timing counts of the control place arbiter.
// Assumes a 25 MHz core clock and 32-bit AXI4-Lite register access.
`ifndef CPA_MAP_SVH
`define CPA_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CPA_OFS_CFG       12'h000
`define CPA_OFS_PRIO      12'h004
`define CPA_OFS_ENTIME    12'h008
`define CPA_OFS_CMD       12'h00c
`define CPA_OFS_STATUS    12'h010

// ****************************************
// Configuration fields
// ****************************************
`define CPA_CFG_DEF_LSB   0
`define CPA_CFG_FMODE_LSB 2
`define CPA_CFG_INDEP     4
`define CPA_CFG_RELMODE   5
`define CPA_CFG_LOCAL_LSB 6
`define CPA_CFG_CONT_LOC  8
`define CPA_CFG_CONT_IO   9
`define CPA_CFG_IOSM_LSB  10
`define CPA_CFG_RST       32'h0000_0001
// Slot i: bits [3i+1:3i] place code, bit 3i+2 slot enabled. PC, local, I/O, fieldbus.
`define CPA_PRIO_RST      32'h0000_0dec

// ****************************************
// Command bits (write-only pulses)
// ****************************************
`define CPA_CMD_TAKE      0
`define CPA_CMD_RELEASE   1
`define CPA_CMD_START     2
`define CPA_CMD_STOP      3
`define CPA_CMD_RESET     4

// ****************************************
// Timing
// ****************************************
`define CPA_CLK_HZ        25000000
`define CPA_EN_MAX_MS     1000
`define CPA_EN_MAX_CYC    (`CPA_EN_MAX_MS * (`CPA_CLK_HZ / 1000))

`endif

// file: hw/cpa_pkg.sv
// Types shared by the control place arbiter.
// Assumes nothing beyond a SystemVerilog compiler.
package cpa_pkg;
	typedef enum logic [1:0] {
		CPA_PC    = 2'h0,
		CPA_LOCAL = 2'h1,
		CPA_FB    = 2'h2,
		CPA_IO    = 2'h3
	} cpa_place_t;

	typedef enum logic [2:0] {
		CPA_EN_IDLE = 3'b001,
		CPA_EN_BUSY = 3'b010,
		CPA_EN_DONE = 3'b100
	} cpa_en_state_t;
endpackage : cpa_pkg

// file: hw/cpa_arbiter.sv
// Control place arbiter: picks the commanding place and gates start, stop and reset.
// Assumes all inputs synchronous to core_clk and a single AXI4-Lite master.
`timescale 1ns/100ps
`include "cpa_map.svh"

module cpa_arbiter #(
	parameter logic [31:0] EN_MAX_CYC = `CPA_EN_MAX_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              local_remote_key,
	input  wire logic              panel_start,
	input  wire logic              panel_stop,
	input  wire logic              panel_reset,
	input  wire logic              fb_force,
	input  wire logic              fb_start,
	input  wire logic              fb_stop,
	input  wire logic              fb_reset,
	input  wire logic              io_force,
	input  wire logic              io_start,
	input  wire logic              io_stop_ok,
	input  wire logic              io_reset,
	input  wire logic              quick_stop_n,
	input  wire logic              energize_done,
	output cpa_pkg::cpa_place_t    active_place,
	output logic                   run_cmd,
	output logic                   fault_reset,
	output logic                   energize_busy,
	output logic                   energize_abort,
	output logic                   energize_fault
);
	import cpa_pkg::*;

	// ****************************************
	// Register slave
	// ****************************************
	logic        aw_held_reg;
	logic [11:0] aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic [31:0] cfg_reg;
	logic [31:0] prio_reg;
	logic [31:0] entime_reg;
	logic [4:0]  cmd_reg;
	logic [31:0] status_word;
	logic        wr_fire;

	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 12'h000;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg == `CPA_OFS_CFG || aw_addr_reg == `CPA_OFS_PRIO ||
				    aw_addr_reg == `CPA_OFS_ENTIME || aw_addr_reg == `CPA_OFS_CMD) begin
					s_axi_bresp <= 2'b00;
				end else begin
					s_axi_bresp <= 2'b10;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = val[8*i +: 8];
			end
		end
		return res;
	endfunction : merge

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg_reg    <= `CPA_CFG_RST;
			prio_reg   <= `CPA_PRIO_RST;
			entime_reg <= EN_MAX_CYC;
			cmd_reg    <= 5'h00;
		end else begin
			cmd_reg <= 5'h00;
			if (wr_fire) begin
				if (aw_addr_reg == `CPA_OFS_CFG) begin
					cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg);
				end else if (aw_addr_reg == `CPA_OFS_PRIO) begin
					prio_reg <= merge(prio_reg, w_data_reg, w_strb_reg);
				end else if (aw_addr_reg == `CPA_OFS_ENTIME) begin
					entime_reg <= merge(entime_reg, w_data_reg, w_strb_reg);
				end else if (aw_addr_reg == `CPA_OFS_CMD && w_strb_reg[0]) begin
					cmd_reg <= w_data_reg[4:0];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				if (s_axi_araddr == `CPA_OFS_CFG) begin
					s_axi_rdata <= cfg_reg;
				end else if (s_axi_araddr == `CPA_OFS_PRIO) begin
					s_axi_rdata <= prio_reg;
				end else if (s_axi_araddr == `CPA_OFS_ENTIME) begin
					s_axi_rdata <= entime_reg;
				end else if (s_axi_araddr == `CPA_OFS_STATUS) begin
					s_axi_rdata <= status_word;
				end else if (s_axi_araddr == `CPA_OFS_CMD) begin
					s_axi_rdata <= 32'h0000_0000;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Forcing and place selection
	// ****************************************
	cpa_place_t  def_place;
	logic [1:0]  force_mode;
	logic [1:0]  local_mode;
	logic [1:0]  io_smode;
	logic        pc_forced_reg;
	logic        fb_forced_reg;
	logic        io_forced_reg;
	logic        fb_force_prev_reg;
	logic        io_force_prev_reg;
	logic [3:0]  forced;
	logic [3:0]  forced_prev_reg;
	cpa_place_t  def_prev_reg;
	cpa_place_t  cand;
	cpa_place_t  active_next;
	logic        reselect;

	assign def_place  = cpa_place_t'(cfg_reg[`CPA_CFG_DEF_LSB +: 2]);
	assign force_mode = cfg_reg[`CPA_CFG_FMODE_LSB +: 2];
	assign local_mode = cfg_reg[`CPA_CFG_LOCAL_LSB +: 2];
	assign io_smode   = cfg_reg[`CPA_CFG_IOSM_LSB +: 2];

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pc_forced_reg     <= 1'b0;
			fb_forced_reg     <= 1'b0;
			io_forced_reg     <= 1'b0;
			fb_force_prev_reg <= 1'b0;
			io_force_prev_reg <= 1'b0;
		end else begin
			fb_force_prev_reg <= fb_force;
			io_force_prev_reg <= io_force;
			if (cmd_reg[`CPA_CMD_TAKE]) begin
				pc_forced_reg <= 1'b1;
			end else if (cmd_reg[`CPA_CMD_RELEASE]) begin
				pc_forced_reg <= 1'b0;
			end
			if (!force_mode[0]) begin
				fb_forced_reg <= fb_force;
			end else if (fb_force && !fb_force_prev_reg) begin
				fb_forced_reg <= !fb_forced_reg;
			end
			if (!force_mode[1]) begin
				io_forced_reg <= io_force;
			end else if (io_force && !io_force_prev_reg) begin
				io_forced_reg <= !io_forced_reg;
			end
		end
	end

	// Local forcing is the panel key, and it vanishes when local mode is denied.
	assign forced = {io_forced_reg, fb_forced_reg, local_remote_key && local_mode != 2'h2, pc_forced_reg};

	always_comb begin
		cand = def_place;
		for (int s = 3; s >= 0; s--) begin
			if (prio_reg[3*s + 2] && forced[prio_reg[3*s +: 2]]) begin
				cand = cpa_place_t'(prio_reg[3*s +: 2]);
			end
		end
		if (pc_forced_reg) begin
			cand = CPA_PC;
		end
	end

	// A fresh forcing or a new default always reselects; a mere release does so only in mode 1.
	assign reselect    = cfg_reg[`CPA_CFG_RELMODE] || |(forced & ~forced_prev_reg) || def_place != def_prev_reg;
	assign active_next = reselect ? cand : active_place;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			active_place    <= CPA_LOCAL;
			forced_prev_reg <= 4'h0;
			def_prev_reg    <= CPA_LOCAL;
		end else begin
			active_place    <= active_next;
			forced_prev_reg <= forced;
			def_prev_reg    <= def_place;
		end
	end

	// ****************************************
	// Start, stop and reset gating
	// ****************************************
	logic io_start_prev_reg;
	logic io_rise;

	assign io_rise = io_start && !io_start_prev_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			run_cmd           <= 1'b0;
			io_start_prev_reg <= 1'b0;
		end else begin
			io_start_prev_reg <= io_start;
			if (!quick_stop_n) begin
				run_cmd <= 1'b0;
			end else if (active_next != active_place) begin
				case (active_next)
					CPA_LOCAL: run_cmd <= run_cmd && cfg_reg[`CPA_CFG_CONT_LOC];
					CPA_IO:    run_cmd <= (io_smode == 2'h0) ? io_start :
					                      run_cmd && cfg_reg[`CPA_CFG_CONT_IO] && io_stop_ok;
					CPA_FB:    run_cmd <= fb_start && !fb_stop;
					default:   run_cmd <= 1'b0;
				endcase
			end else begin
				case (active_place)
					CPA_PC: begin
						if (cmd_reg[`CPA_CMD_STOP]) begin
							run_cmd <= 1'b0;
						end else if (cmd_reg[`CPA_CMD_START]) begin
							run_cmd <= 1'b1;
						end
					end
					CPA_LOCAL: begin
						if (panel_stop) begin
							run_cmd <= 1'b0;
						end else if (panel_start && local_mode == 2'h0) begin
							run_cmd <= 1'b1;
						end
					end
					CPA_FB: begin
						run_cmd <= fb_start && !fb_stop;
					end
					default: begin
						if (!io_stop_ok) begin
							run_cmd <= 1'b0;
						end else if (io_smode == 2'h0) begin
							run_cmd <= io_start;
						end else if (io_rise) begin
							run_cmd <= 1'b1;
						end else if (io_smode == 2'h1 && !io_start) begin
							run_cmd <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	logic [3:0] rst_src;
	assign rst_src = {io_reset, fb_reset, panel_reset, cmd_reg[`CPA_CMD_RESET]};

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fault_reset <= 1'b0;
		end else if (cfg_reg[`CPA_CFG_INDEP]) begin
			fault_reset <= |rst_src;
		end else begin
			fault_reset <= rst_src[active_place];
		end
	end

	// ****************************************
	// Energization supervision
	// ****************************************
	cpa_en_state_t en_state_reg;
	logic [31:0]   en_cnt_reg;
	logic          run_prev_reg;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			en_state_reg   <= CPA_EN_IDLE;
			en_cnt_reg     <= 32'h0000_0000;
			run_prev_reg   <= 1'b0;
			energize_abort <= 1'b0;
			energize_fault <= 1'b0;
		end else begin
			run_prev_reg   <= run_cmd;
			energize_abort <= 1'b0;
			if (fault_reset) begin
				energize_fault <= 1'b0;
			end
			case (en_state_reg)
				CPA_EN_IDLE: begin
					en_cnt_reg <= 32'h0000_0000;
					if (run_cmd && !run_prev_reg) begin
						en_state_reg <= CPA_EN_BUSY;
					end
				end
				CPA_EN_BUSY: begin
					en_cnt_reg <= en_cnt_reg + 32'h0000_0001;
					if (energize_done) begin
						en_state_reg <= CPA_EN_DONE;
					end else if (!run_cmd) begin
						en_state_reg <= CPA_EN_IDLE;
					end else if (en_cnt_reg + 32'h0000_0001 >= entime_reg) begin
						en_state_reg   <= CPA_EN_IDLE;
						energize_abort <= 1'b1;
						energize_fault <= 1'b1;
					end
				end
				default: begin
					if (!run_cmd) begin
						en_state_reg <= CPA_EN_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			energize_busy <= 1'b0;
		end else begin
			energize_busy <= en_state_reg == CPA_EN_BUSY;
		end
	end

	assign status_word = {23'h000000, en_state_reg == CPA_EN_BUSY, energize_fault, run_cmd, forced, active_place};

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	quick_stop_a: assert property (!quick_stop_n |=> !run_cmd)
		else $error("run stayed on after quick stop");
	pc_take_a: assert property (cmd_reg[`CPA_CMD_TAKE] |=> ##1 active_place == CPA_PC)
		else $error("pc tool did not take command");
	io_stop_a: assert property (active_place == CPA_IO && active_next == CPA_IO && !io_stop_ok |=> !run_cmd)
		else $error("io stop input ignored");
	io_level_a: assert property (quick_stop_n && io_stop_ok && io_smode == 2'h0 && active_place == CPA_IO &&
	                             active_next == CPA_IO |=> run_cmd == $past(io_start))
		else $error("io state start not followed");
	io_relatch_a: assert property (active_place == CPA_IO && active_next == CPA_IO && io_smode == 2'h1 &&
	                               !run_cmd && io_start && io_start_prev_reg |=> !run_cmd)
		else $error("held io start relatched");
	local_deny_a: assert property (active_place == CPA_LOCAL && active_next == CPA_LOCAL && local_mode != 2'h0 &&
	                               !run_cmd |=> !run_cmd)
		else $error("local start not blocked");
	reset_gate_a: assert property (!cfg_reg[`CPA_CFG_INDEP] && active_place != CPA_IO && !fb_reset &&
	                               !panel_reset && !cmd_reg[`CPA_CMD_RESET] |=> !fault_reset)
		else $error("reset taken from inactive place");
	en_timeout_a: assert property (energize_abort |-> energize_fault && $past(en_state_reg) == CPA_EN_BUSY)
		else $error("abort without running timeout");
	fb_toggle_a: assert property (force_mode[0] && fb_force && !fb_force_prev_reg |=> fb_forced_reg != $past(fb_forced_reg))
		else $error("fieldbus forcing did not toggle");

	pc_run_c: cover property (active_place == CPA_PC ##1 run_cmd);
	io_edge_c: cover property (active_place == CPA_IO && io_smode == 2'h2 ##1 run_cmd);
	timeout_c: cover property (energize_abort);
endmodule : cpa_arbiter

// file: verification/cpa_far_model.sv
// Far-side model: operator inputs, panel, fieldbus inputs and the filter energization hardware.
// Assumes the bench sets the wanted input levels on want, one bit per input.
`timescale 1ns/100ps

module cpa_far_model (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [12:0] want,
	input  wire logic [7:0]  done_delay,
	input  wire logic        energize_busy,
	output logic             local_remote_key,
	output logic             panel_start,
	output logic             panel_stop,
	output logic             panel_reset,
	output logic             fb_force,
	output logic             fb_start,
	output logic             fb_stop,
	output logic             fb_reset,
	output logic             io_force,
	output logic             io_start,
	output logic             io_stop_ok,
	output logic             io_reset,
	output logic             quick_stop_n,
	output logic             energize_done
);
	logic [7:0] busy_cnt;

	// Inputs and keys change just after an edge, as any synchronous operator source would.
	always_ff @(posedge core_clk) begin
		{quick_stop_n, io_reset, io_stop_ok, io_start, io_force, fb_reset, fb_stop, fb_start, fb_force,
			panel_reset, panel_stop, panel_start, local_remote_key} <= want;
	end

	// Energization ends done_delay cycles into a busy period, so a large delay never ends in time.
	always_ff @(posedge core_clk) begin
		if (srst || !energize_busy) begin
			busy_cnt      <= 8'h00;
			energize_done <= 1'b0;
		end else begin
			if (busy_cnt != 8'hff)
				busy_cnt <= busy_cnt + 8'h01;
			energize_done <= (busy_cnt >= done_delay);
		end
	end
endmodule : cpa_far_model

// file: verification/cpa_arbiter_tb.sv
// Bench for the control place arbiter: AXI4-Lite register tasks and operator input sequences.
// Assumes the far-side model applies want one edge after the bench changes it.
`timescale 1ns/100ps
`include "cpa_map.svh"

module cpa_arbiter_tb;
	import cpa_pkg::*;

	localparam int KEY = 0, PST = 1, PRS = 3, FBF = 4, IOF = 8, IOS = 9, IOK = 10, IOR = 11, QSN = 12;

	logic        core_clk = 1'b0, srst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [12:0] want = 13'h1400;
	logic [7:0]  dly = 8'h05;
	logic        local_remote_key, panel_start, panel_stop, panel_reset, fb_force, fb_start, fb_stop;
	logic        fb_reset, io_force, io_start, io_stop_ok, io_reset, quick_stop_n, energize_done;
	logic        run_cmd, fault_reset, energize_busy, energize_abort, energize_fault;
	cpa_place_t  active_place;
	int          n_mismatch = 0, checks = 0, n_frst = 0, n_abort = 0, b;

	always #20 core_clk = ~core_clk;

	cpa_arbiter #(.EN_MAX_CYC(32'h0000_0014)) i_dut (
		.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.local_remote_key, .panel_start, .panel_stop, .panel_reset, .fb_force, .fb_start, .fb_stop,
		.fb_reset, .io_force, .io_start, .io_stop_ok, .io_reset, .quick_stop_n, .energize_done,
		.active_place, .run_cmd, .fault_reset, .energize_busy, .energize_abort, .energize_fault
	);

	cpa_far_model i_far (
		.core_clk, .srst, .want, .done_delay(dly), .energize_busy, .local_remote_key, .panel_start,
		.panel_stop, .panel_reset, .fb_force, .fb_start, .fb_stop, .fb_reset, .io_force, .io_start,
		.io_stop_ok, .io_reset, .quick_stop_n, .energize_done
	);

	// Pulses last one cycle, so they are counted at every edge rather than polled.
	always @(posedge core_clk) begin
		if (fault_reset === 1'b1)
			n_frst++;
		if (energize_abort === 1'b1)
			n_abort++;
	end

	// ********
	// Tasks
	// ********
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : compare

	function automatic logic [31:0] obs(input int sel);
		case (sel)
			0: return {30'h0, active_place};
			1: return {31'h0, run_cmd};
			2: return {31'h0, energize_fault};
			3: return n_frst;
			5: return {31'h0, energize_busy};
			default: return n_abort;
		endcase
	endfunction : obs

	// Poll mode waits up to 40 cycles for the expected value; hold mode lets 12 cycles pass and checks only the value at the end.
	task automatic ex(input string name, input int sel, input logic [31:0] exp, input bit poll);
		int i;
		for (i = 0; i < (poll ? 40 : 12); i++) begin
			@(negedge core_clk);
			if (poll && obs(sel) === exp)
				break;
		end
		compare(name, exp, obs(sel));
		if (poll && obs(sel) !== exp)
			test_done();
	endtask : ex

	task automatic drv(input int idx, input logic v);
		@(posedge core_clk);
		want[idx] <= v;
	endtask : drv

	task automatic pls(input int idx);
		drv(idx, 1'b1);
		drv(idx, 1'b0);
	endtask : pls

	// For a read, d is the expected data; er is the expected response code.
	task automatic axi(input bit rd, input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ad, wd;
		int i;
		@(posedge core_clk);
		if (rd) begin
			s_axi_araddr  <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready  <= 1'b1;
		end else begin
			s_axi_awaddr  <= a;
			s_axi_wdata   <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid  <= 1'b1;
			s_axi_bready  <= 1'b1;
		end
		ad = 1'b0;
		wd = rd;
		for (i = 0; i < 40; i++) begin
			@(posedge core_clk);
			if (rd && s_axi_rvalid === 1'b1) begin
				s_axi_rready <= 1'b0;
				compare("rresp", er, s_axi_rresp);
				compare("rdata", d, s_axi_rdata);
				break;
			end
			if (!rd && ad && wd && s_axi_bvalid === 1'b1) begin
				s_axi_bready <= 1'b0;
				compare("bresp", er, s_axi_bresp);
				break;
			end
			if (!ad && (rd ? s_axi_arready : s_axi_awready) === 1'b1) begin
				s_axi_arvalid <= 1'b0;
				s_axi_awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		if (i == 40) begin
			n_mismatch++;
			$display("unexpected bus answer: expected response, seen none");
			test_done();
		end
	endtask : axi

	// Fields packed from bit 0: default, forcing mode, indep reset, release, local, cont local/io, start.
	task automatic setc(input logic [1:0] df, fm, input logic ind, rl, input logic [1:0] lc,
		input logic cl, ci, input logic [1:0] sm);
		axi(1'b0, `CPA_OFS_CFG, {20'h0, sm, ci, cl, lc, rl, ind, fm, df}, 2'h0);
	endtask : setc

	function automatic logic [31:0] prio(input logic [7:0] ord, input logic [3:0] en);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < 4; i++)
			w[3*i +: 3] = {en[i], ord[2*i +: 2]};
		return w;
	endfunction : prio

	// ********
	// Sequence
	// ********
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		ex("place", 0, 32'h1, 0);
		axi(1'b1, `CPA_OFS_CFG, 32'h1, 2'h0);
		axi(1'b1, `CPA_OFS_PRIO, prio(8'hb4, 4'hf), 2'h0);
		axi(1'b1, `CPA_OFS_ENTIME, 32'h0000_0014, 2'h0);
		axi(1'b1, `CPA_OFS_STATUS, 32'h0000_0001, 2'h0);
		axi(1'b1, 12'h014, 32'h0, 2'h2);
		axi(1'b0, `CPA_OFS_STATUS, 32'h0, 2'h2);
		for (int p = 0; p < 4; p++) begin
			setc(p[1:0], 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
			ex("default place", 0, p, 1);
		end
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
		drv(IOF, 1'b1);
		drv(FBF, 1'b1);
		ex("forced place", 0, 32'h3, 1);
		drv(IOF, 1'b0);
		ex("fallback", 0, 32'h2, 1);
		drv(FBF, 1'b0);
		ex("released", 0, 32'h1, 1);
		axi(1'b0, `CPA_OFS_PRIO, prio(8'he4, 4'hf), 2'h0);
		drv(IOF, 1'b1);
		drv(FBF, 1'b1);
		ex("slot order", 0, 32'h2, 1);
		axi(1'b0, `CPA_OFS_PRIO, prio(8'he4, 4'h7), 2'h0);
		drv(FBF, 1'b0);
		ex("unranked", 0, 32'h1, 1);
		axi(1'b0, `CPA_OFS_PRIO, prio(8'hb4, 4'hf), 2'h0);
		ex("ranked", 0, 32'h3, 1);
		axi(1'b0, `CPA_OFS_CMD, 32'h1 << `CPA_CMD_TAKE, 2'h0);
		ex("take", 0, 32'h0, 1);
		axi(1'b0, `CPA_OFS_CMD, 32'h1 << `CPA_CMD_RELEASE, 2'h0);
		ex("release", 0, 32'h3, 1);
		setc(2'h1, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0);
		axi(1'b0, `CPA_OFS_CMD, 32'h1 << `CPA_CMD_TAKE, 2'h0);
		ex("take", 0, 32'h0, 1);
		axi(1'b0, `CPA_OFS_CMD, 32'h1 << `CPA_CMD_RELEASE, 2'h0);
		ex("retain", 0, 32'h0, 0);
		drv(IOF, 1'b0);
		drv(IOF, 1'b1);
		ex("new forcing", 0, 32'h3, 1);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
		drv(PST, 1'b1);
		ex("panel start", 1, 32'h0, 0);
		drv(PST, 1'b0);
		drv(IOS, 1'b1);
		ex("level start", 1, 32'h1, 1);
		drv(IOK, 1'b0);
		ex("io stop", 1, 32'h0, 1);
		drv(IOK, 1'b1);
		ex("level start", 1, 32'h1, 1);
		drv(IOS, 1'b0);
		ex("level drop", 1, 32'h0, 1);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 2'h1);
		drv(IOS, 1'b1);
		ex("edge start", 1, 32'h1, 1);
		drv(IOK, 1'b0);
		ex("edge stop", 1, 32'h0, 1);
		drv(IOK, 1'b1);
		ex("no relatch", 1, 32'h0, 0);
		drv(IOS, 1'b0);
		drv(IOS, 1'b1);
		ex("edge start", 1, 32'h1, 1);
		drv(IOS, 1'b0);
		ex("input false", 1, 32'h0, 1);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 2'h2);
		pls(IOS);
		ex("pulse latch", 1, 32'h1, 0);
		drv(KEY, 1'b1);
		ex("key place", 0, 32'h1, 1);
		ex("keep local", 1, 32'h1, 0);
		drv(KEY, 1'b0);
		ex("back to io", 0, 32'h3, 1);
		ex("keep io", 1, 32'h1, 0);
		drv(IOK, 1'b0);
		ex("pulse stop", 1, 32'h0, 1);
		drv(IOK, 1'b1);
		pls(IOS);
		ex("pulse latch", 1, 32'h1, 1);
		drv(QSN, 1'b0);
		ex("quick stop", 1, 32'h0, 1);
		drv(QSN, 1'b1);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1, 2'h2);
		pls(IOS);
		ex("pulse latch", 1, 32'h1, 1);
		drv(KEY, 1'b1);
		ex("stop on local", 1, 32'h0, 1);
		drv(KEY, 1'b0);
		ex("back to io", 0, 32'h3, 1);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1, 2'h2);
		drv(KEY, 1'b1);
		ex("key refused", 0, 32'h3, 0);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h1, 1'b0, 1'b1, 2'h2);
		ex("key place", 0, 32'h1, 1);
		drv(PST, 1'b1);
		ex("local start", 1, 32'h0, 0);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b1, 2'h2);
		ex("local start", 1, 32'h1, 1);
		drv(PST, 1'b0);
		drv(KEY, 1'b0);
		ex("back to io", 0, 32'h3, 1);
		drv(IOK, 1'b0);
		ex("io stop", 1, 32'h0, 1);
		drv(IOK, 1'b1);
		setc(2'h1, 2'h0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
		b = n_frst;
		pls(PRS);
		ex("reset refused", 3, b, 0);
		pls(IOR);
		ex("io reset", 3, b + 1, 1);
		setc(2'h1, 2'h0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
		pls(PRS);
		ex("any reset", 3, b + 2, 1);
		drv(IOF, 1'b0);
		ex("released", 0, 32'h1, 1);
		for (int m = 1; m < 4; m++) begin
			setc(2'h1, m[1:0], 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
			pls(m == 1 ? FBF : IOF);
			ex("toggle on", 0, m == 1 ? 2 : 3, 1);
			pls(m == 1 ? FBF : IOF);
			ex("toggle off", 0, 32'h1, 1);
		end
		setc(2'h1, 2'h0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0);
		drv(IOF, 1'b1);
		ex("io place", 0, 32'h3, 1);
		b = n_abort;
		drv(IOS, 1'b1);
		ex("run", 1, 32'h1, 1);
		ex("no fault", 2, 32'h0, 0);
		ex("no abort", 4, b, 0);
		drv(IOS, 1'b0);
		ex("stopped", 1, 32'h0, 1);
		@(posedge core_clk);
		dly <= 8'hff;
		drv(IOS, 1'b1);
		ex("run", 1, 32'h1, 1);
		ex("busy", 5, 32'h1, 1);
		ex("early abort", 4, b, 0);
		ex("abort", 4, b + 1, 1);
		ex("busy", 5, 32'h0, 1);
		ex("fault", 2, 32'h1, 1);
		pls(IOR);
		ex("fault cleared", 2, 32'h0, 1);
		drv(IOS, 1'b0);
		test_done();
	end
endmodule : cpa_arbiter_tb
